// file: design/epat_cfg.svh
/*
  constants for the eeprom page access timer: apb byte offsets, control
  field positions, reset values and prescaler timing.
  assumes inclusion by bare name from the core design file.
*/
`ifndef EPAT_CFG_SVH
`define EPAT_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define EPAT_OFF_ADDR    12'h000
`define EPAT_OFF_DATA    12'h004
`define EPAT_OFF_CTRL    12'h008
`define EPAT_OFF_RELOAD  12'h00c
`define EPAT_OFF_COUNT   12'h010
`define EPAT_OFF_STATUS  12'h014

// ****************************************
// control and status fields
// ****************************************
`define EPAT_CTL_MODE1   1
`define EPAT_CTL_MODE2   2
`define EPAT_CTL_MODE3   3
`define EPAT_CTL_RUN     4
`define EPAT_CTL_CIP     7
`define EPAT_STS_UFL     0

// ****************************************
// reset values and timing
// ****************************************
`define EPAT_RST_BYTE    8'h00
`define EPAT_CRYSTAL_DIV 480
`define EPAT_PRE_MAX     9'h1df

`endif

// file: design/epat_core.sv
/*
  eeprom page access controller with shared 8-bit countdown timer and an
  apb slave for address, data port, control, reload, count and status.
  assumes a 10 MHz clk as the crystal clock, synchronous active-high rst,
  and that the 256-byte array is the internal memory here.
*/
// Local design decisions: the address map and the APB slave port.
// Summary of operation
// [RULE1] data read increments whole address register
// [RULE2] software sets address then reads data
// [RULE3] data write loads latch picked by low bits
// [RULE4] software selects increment mode before presetting
// [RULE5] write cycle ORs flagged latches into page
// [RULE6] cip plus mode two starts write cycle
// [RULE7] write cycles increment address, wrapping pages
// [RULE8] cip plus mode three does erase then write
// [RULE9] cip plus modes three two one erases
// [RULE10] erase cycle leaves address unchanged
// [RULE11] 8-bit counter decrements every 480 clocks
// [RULE12] cip start loads counter from reload
// [RULE13] erase/write reloads counter after first underflow
// [RULE14] final underflow stops, flags, clears cip, modes
// [RULE15] software loads reload for 5 ms interval; the bench loads 01, so each phase lasts 960 clocks
// [RULE16] run bit loads, underflow reloads and flags
// [RULE17] clearing run freezes; setting restarts from reload
// [RULE18] counter readable while running, undisturbed
// [RULE19] software erases before write for exact copy
// [RULE20] software never mixes timer and eeprom use
// [RULE21] latches OR-accumulate, cleared at cycle end
// [RULE22] latch write sets flag; flags cleared end
// [RULE23] increment stops at latch three
// [RULE24] unflagged page bytes stay unchanged
// [RULE25] prescaler divides by 480 while running
`timescale 1ns/1ps
`include "epat_cfg.svh"
module epat_core
  import epat_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************
  // apb decode
  // ****************************************
  logic             acc;
  logic             done;
  logic             wr;
  logic             rd;
  logic             hit_addr;
  logic             hit_data;
  logic             hit_ctrl;
  logic             hit_rel;
  logic             hit_cnt;
  logic             hit_sts;
  logic             mapped;
  // each access takes one wait state: setup, access, done
  assign acc      = psel & penable & ~pready;
  assign done     = psel & penable & pready;
  assign wr       = done & pwrite;
  assign rd       = acc & ~pwrite;
  assign hit_addr = paddr == `EPAT_OFF_ADDR;
  assign hit_data = paddr == `EPAT_OFF_DATA;
  assign hit_ctrl = paddr == `EPAT_OFF_CTRL;
  assign hit_rel  = paddr == `EPAT_OFF_RELOAD;
  assign hit_cnt  = paddr == `EPAT_OFF_COUNT;
  assign hit_sts  = paddr == `EPAT_OFF_STATUS;
  assign mapped   = hit_addr | hit_data | hit_ctrl | hit_rel | hit_cnt
                    | hit_sts;

  // ****************************************
  // state
  // ****************************************
  epat_byte_t       lane_q [0:3];
  epat_byte_t       latch [0:3];
  logic       [3:0] byte_select_flags;
  epat_byte_t       ee_addr;
  logic             cycle_in_progress_bit;
  logic             mode_bit_one;
  logic             mode_bit_two;
  logic             mode_bit_three;
  logic             timer_run_bit;
  epat_byte_t       countdown_reload_reg;
  epat_byte_t       countdown_value;
  logic             countdown_underflow_flag;
  logic       [8:0] pre;
  epat_state_e      state;

  // ****************************************
  // control decode
  // ****************************************
  logic             start;
  logic             ctl_cip;
  logic             ctl_m1;
  logic             ctl_m2;
  logic             ctl_m3;
  logic             is_erase;
  logic             is_ew;
  logic             is_wr;
  logic             running;
  logic             tick;
  logic             uflow;
  logic             last_uflow;
  logic             data_wr;
  logic             data_rd;
  logic             run_rise;
  logic             ctl_run;
  assign ctl_cip  = pwdata[`EPAT_CTL_CIP];
  assign ctl_m1   = pwdata[`EPAT_CTL_MODE1];
  assign ctl_m2   = pwdata[`EPAT_CTL_MODE2];
  assign ctl_m3   = pwdata[`EPAT_CTL_MODE3];
  assign ctl_run  = pwdata[`EPAT_CTL_RUN];
  assign is_erase = ctl_m3 & ctl_m2 & ctl_m1;                  // RULE9
  assign is_ew    = ctl_m3 & ~ctl_m2 & ~ctl_m1;                // RULE8
  assign is_wr    = ctl_m2 & ~ctl_m3 & ~ctl_m1;                // RULE6
  // a new cycle is refused while one is running
  assign start    = wr & hit_ctrl & ctl_cip & ~cycle_in_progress_bit
                    & (is_erase | is_ew | is_wr);
  assign run_rise = wr & hit_ctrl & ctl_run & ~timer_run_bit
                    & ~cycle_in_progress_bit;
  assign running  = (state != EPAT_IDLE) | timer_run_bit;
  assign tick     = running & (pre == `EPAT_PRE_MAX);          // RULE11
  assign uflow    = tick & (countdown_value == `EPAT_RST_BYTE);
  assign last_uflow = uflow & ((state == EPAT_WRITE)
                    | (state == EPAT_ERASE & mode_bit_one));    // RULE14
  assign data_wr  = wr & hit_data & ~cycle_in_progress_bit;
  assign data_rd  = done & ~pwrite & hit_data;

  // ****************************************
  // apb answer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (rd)
      begin
        prdata <= 32'h0;
        // count read is a plain sample and leaves the count alone
        if (hit_addr) prdata[7:0] <= ee_addr;
        if (hit_data) prdata[7:0] <= lane_q[ee_addr[1:0]];       // RULE2
        if (hit_ctrl) prdata[7:0] <= {cycle_in_progress_bit, 2'b00,
          timer_run_bit, mode_bit_three, mode_bit_two, mode_bit_one, 1'b0};
        if (hit_rel)  prdata[7:0] <= countdown_reload_reg;
        if (hit_cnt)  prdata[7:0] <= countdown_value;            // RULE18
        if (hit_sts)  prdata[7:0] <= {7'h0, countdown_underflow_flag};
      end
    end
  end

  // ****************************************
  // prescaler
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst | ~running | start | run_rise)
      pre <= 9'h000;
    else if (pre == `EPAT_PRE_MAX)
      pre <= 9'h000;
    else
      pre <= pre + 9'h001;                                     // RULE25
  end

  // ****************************************
  // sequencer and counter
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state                 <= EPAT_IDLE;
      cycle_in_progress_bit <= 1'b0;
      mode_bit_one          <= 1'b0;
      mode_bit_two          <= 1'b0;
      mode_bit_three        <= 1'b0;
      timer_run_bit         <= 1'b0;
      countdown_reload_reg  <= `EPAT_RST_BYTE;
      countdown_value       <= `EPAT_RST_BYTE;
    end
    else
    begin
      if (wr & hit_rel)
        countdown_reload_reg <= pwdata[7:0];
      if (wr & hit_ctrl & ~cycle_in_progress_bit)
      begin
        timer_run_bit  <= ctl_run;                             // RULE17
        mode_bit_one   <= ctl_m1;
        mode_bit_two   <= ctl_m2;
        mode_bit_three <= ctl_m3;
      end
      if (start)
      begin
        cycle_in_progress_bit <= 1'b1;
        countdown_value <= countdown_reload_reg;               // RULE12
        state <= is_wr ? EPAT_WRITE : EPAT_ERASE;
      end
      else if (run_rise)
        countdown_value <= countdown_reload_reg;               // RULE16
      else if (last_uflow)
      begin
        state                 <= EPAT_IDLE;
        cycle_in_progress_bit <= 1'b0;                         // RULE14
        mode_bit_one          <= 1'b0;
        mode_bit_two          <= 1'b0;
        mode_bit_three        <= 1'b0;
      end
      else if (uflow & state == EPAT_ERASE)
      begin
        state           <= EPAT_WRITE;
        countdown_value <= countdown_reload_reg;               // RULE13
      end
      else if (uflow)
        countdown_value <= countdown_reload_reg;               // RULE16
      else if (tick)
        countdown_value <= countdown_value - 8'h01;            // RULE11
    end
  end

  // set wins over a clearing write to the status register
  always_ff @(posedge clk)
  begin
    if (rst)
      countdown_underflow_flag <= 1'b0;
    else if (last_uflow | (uflow & state == EPAT_IDLE))
      countdown_underflow_flag <= 1'b1;                        // RULE14
    else if (wr & hit_sts & pwdata[`EPAT_STS_UFL])
      countdown_underflow_flag <= 1'b0;
  end

  // ****************************************
  // address register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      ee_addr <= `EPAT_RST_BYTE;
    else if (wr & hit_addr & ~cycle_in_progress_bit)
      ee_addr <= pwdata[7:0];
    else if (data_rd)
      ee_addr <= ee_addr + 8'h01;                              // RULE1
    else if (data_wr & mode_bit_two & ~mode_bit_three
             & ~(&ee_addr[1:0]))
      ee_addr <= ee_addr + 8'h01;                              // RULE23
    else if (last_uflow & ~mode_bit_one)
      ee_addr <= ee_addr + 8'h01;                              // RULE7 RULE10
  end

  // ****************************************
  // latches, flags and array, per byte lane
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : lane
      logic       sel;
      epat_byte_t bank [0:63];
      assign sel       = byte_select_flags[g];                 // RULE24
      assign lane_q[g] = bank[ee_addr[7:2]];
      always_ff @(posedge clk)
      begin
        if (rst | last_uflow)
        begin
          latch[g]             <= `EPAT_RST_BYTE;              // RULE21
          byte_select_flags[g] <= 1'b0;                        // RULE22
        end
        else if (data_wr & ee_addr[1:0] == 2'(g))
        begin
          latch[g]             <= latch[g] | pwdata[7:0];      // RULE3
          byte_select_flags[g] <= 1'b1;                        // RULE22
        end
      end
      // each lane owns its bank, so one process writes it; phase end only
      always_ff @(posedge clk)
      begin
        if (!rst & uflow & sel & state == EPAT_ERASE)
          bank[ee_addr[7:2]] <= `EPAT_RST_BYTE;
        else if (!rst & uflow & sel & state == EPAT_WRITE)
          bank[ee_addr[7:2]] <= lane_q[g] | latch[g];          // RULE5
      end
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  sequence s_start_write;
    start & is_wr;
  endsequence

  a_start_loads: assert property (@(posedge clk) disable iff (rst)
    start |=> countdown_value == $past(countdown_reload_reg)) // RULE12
    else $error("counter not loaded at start");
  a_write_state: assert property (@(posedge clk) disable iff (rst)
    s_start_write |=> state == EPAT_WRITE && cycle_in_progress_bit) // RULE6
    else $error("write cycle not entered");
  a_end_clears: assert property (@(posedge clk) disable iff (rst)
    last_uflow |=> !cycle_in_progress_bit && !mode_bit_two
      && countdown_underflow_flag && byte_select_flags == 4'h0) // RULE14
    else $error("cycle end did not clear state");
  a_erase_keeps: assert property (@(posedge clk) disable iff (rst)
    last_uflow && mode_bit_one && !data_rd |=> $stable(ee_addr)) // RULE10
    else $error("erase moved address");
  a_read_incr: assert property (@(posedge clk) disable iff (rst)
    data_rd |=> ee_addr == $past(ee_addr) + 8'h01) // RULE1
    else $error("read did not advance address");
  a_tick_gap: assert property (@(posedge clk) disable iff (rst)
    tick && running |=> !tick [*8]) // RULE11
    else $error("decrement strobe too frequent");
  a_ew_reload: assert property (@(posedge clk) disable iff (rst)
    uflow && state == EPAT_ERASE && !mode_bit_one
      |=> state == EPAT_WRITE
      && countdown_value == $past(countdown_reload_reg)) // RULE13
    else $error("erase/write did not reload");
  a_latch_stop: assert property (@(posedge clk) disable iff (rst)
    data_wr && ee_addr[1:0] == 2'b11 |=> ee_addr[1:0] == 2'b11) // RULE23
    else $error("latch select passed three");
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    data_wr |=> byte_select_flags[$past(ee_addr[1:0])]) // RULE22
    else $error("flag not set on latch write");

endmodule

// file: design/epat_pkg.sv
/*
  types for the eeprom page access timer.
  assumes no other package.
*/
package epat_pkg;
  typedef enum logic [1:0]
  {
    EPAT_IDLE  = 2'b00,
    EPAT_ERASE = 2'b01,
    EPAT_WRITE = 2'b11
  } epat_state_e;
  typedef logic [7:0] epat_byte_t;
endpackage

// file: sim/epat_host.sv
/*
  apb host model: the software side of the eeprom page access timer.
  assumes a registered slave that raises pready after a wait state.
*/
`timescale 1ns/1ps
module epat_host
(
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  logic err;
  int   stalls;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
    err     = 1'b0;
    stalls  = 0;
  end

  // ****************************************
  // one transfer
  // ****************************************
  // request held until pready is sampled high, bounded so a hang ends
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
            output logic [7:0] q);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    // a transfer that never got its answer counts against the run
    if (pready !== 1'b1)
      stalls++;
    q   = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// file: sim/testbench.sv
/*
  self-checking bench for the eeprom page access timer.
  assumes epat_core with its internal array and a 10 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import epat_pkg::*;
;
  typedef struct
  {
    logic        w;
    logic [11:0] a;
    epat_byte_t  d;
    epat_byte_t  e;
  } epat_row_s;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  epat_byte_t  q;
  int          mismatches;
  int          checks;
  int          cyc;
  int          t0;
  epat_row_s   rows[9] = '{'{0, 12'h000, 8'h00, 8'h00},
    '{0, 12'h008, 8'h00, 8'h00}, '{0, 12'h00c, 8'h00, 8'h00},
    '{0, 12'h010, 8'h00, 8'h00}, '{0, 12'h014, 8'h00, 8'h00},
    '{1, 12'h010, 8'h55, 8'h00}, '{0, 12'h010, 8'h00, 8'h00},
    '{1, 12'h00c, 8'h01, 8'h00}, '{0, 12'h00c, 8'h00, 8'h01}};

  epat_core uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  epat_host host (.clk(clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ****************************************
  // helpers
  // ****************************************
  task chk(input string n, input epat_byte_t e, input epat_byte_t g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task chk_span(input int lo, input int g);
    checks++;
    if (g < lo - 2 || g > lo + 12)
    begin
      mismatches++;
      $display("ERROR cycle_span expected %0d seen %0d", lo, g);
    end
  endtask

  task wr(input logic [11:0] a, input epat_byte_t d);
    host.xfer(1'b1, a, d, q);
  endtask

  task rd(input logic [11:0] a, input epat_byte_t e, input string n);
    host.xfer(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask

  // start a page cycle, then poll the control word until it clears
  task run_cycle(input epat_byte_t c, input int span);
    int n;
    wr(12'h008, c);
    t0 = cyc;
    n = 0;
    do
    begin
      host.xfer(1'b0, 12'h008, 8'h00, q);
      n++;
    end
    while (q[7] !== 1'b0 && n < 1000);
    chk_span(span, cyc - t0);
    chk("ctrl_end", 8'h00, q);
  endtask

  task summarize;
    mismatches = mismatches + host.stalls;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #(20000 * 100);
    mismatches++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].e, "reg");
    host.xfer(1'b1, 12'h018, 8'hff, q);
    chk("slverr", 8'h01, {7'h00, host.err});
    // erase page 0 first so later writes give an exact copy
    wr(12'h000, 8'h00);
    wr(12'h008, 8'h04);
    repeat (5) wr(12'h004, 8'hff);
    rd(12'h000, 8'h03, "latch_sel");
    run_cycle(8'h8e, 960);
    rd(12'h014, 8'h01, "ufl");
    rd(12'h000, 8'h03, "addr_erase");
    wr(12'h014, 8'h01);
    wr(12'h000, 8'h00);
    for (int i = 0; i < 4; i++) rd(12'h004, 8'h00, "erased");
    rd(12'h000, 8'h04, "addr_inc");
    wr(12'h008, 8'h00);
    wr(12'h000, 8'h01);
    wr(12'h004, 8'h01);
    wr(12'h004, 8'h02);
    wr(12'h000, 8'h03);
    wr(12'h004, 8'h40);
    run_cycle(8'h84, 960);
    rd(12'h000, 8'h04, "addr_wrap");
    wr(12'h000, 8'h00);
    foreach (rows[i])
      if (i < 4) rd(12'h004, (i == 1) ? 8'h03 : (i == 3) ? 8'h40 : 8'h00,
        "page_w");
    wr(12'h000, 8'h01);
    wr(12'h004, 8'h0c);
    run_cycle(8'h88, 1920);
    rd(12'h000, 8'h02, "addr_ew");
    wr(12'h000, 8'h01);
    rd(12'h004, 8'h0c, "page_ew");
    rd(12'h004, 8'h00, "unflagged");
    rd(12'h004, 8'h40, "kept");
    // general-purpose timer only once the page cycles are over
    wr(12'h014, 8'h01);
    wr(12'h00c, 8'h02);
    wr(12'h008, 8'h10);
    rd(12'h010, 8'h02, "run_load");
    repeat (1500) @(posedge clk);
    rd(12'h014, 8'h01, "tmr_ufl");
    rd(12'h010, 8'h02, "tmr_reload");
    repeat (500) @(posedge clk);
    wr(12'h008, 8'h00);
    repeat (600) @(posedge clk);
    rd(12'h010, 8'h01, "frozen");
    wr(12'h008, 8'h10);
    rd(12'h010, 8'h02, "restart");
    // reset in mid-run while the timer counts and the flag is set
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(12'h00c, 8'h00, "rst_reload");
    rd(12'h010, 8'h00, "rst_count");
    rd(12'h014, 8'h00, "rst_ufl");
    rd(12'h000, 8'h00, "rst_addr");
    summarize();
  end
endmodule
